// >>> rtl/bpadc_pkg.sv
package bpadc_pkg;

  // register offsets on the serial control port
  localparam logic [6:0] REG_STANDBY = 7'h00;
  localparam logic [6:0] REG_DECIM = 7'h07;
  localparam logic [6:0] REG_TUNE = 7'h1C;
  localparam logic [6:0] REG_LC_COARSE = 7'h1D;
  localparam logic [6:0] REG_LC_FINE = 7'h1E;
  localparam logic [6:0] REG_RC_CODE = 7'h1F;

  // values after reset
  localparam logic [7:0] STANDBY_RESET = 8'hFF;
  localparam logic [4:0] DECIM_RESET = 5'h01;
  localparam logic [1:0] TUNE_RESET = 2'h0;
  localparam logic [2:0] LC_COARSE_RESET = 3'h0;
  localparam logic [5:0] LC_FINE_RESET = 6'h00;
  localparam logic [7:0] RC_CODE_RESET = 8'h00;

  // field positions
  localparam int BLOCK_POWER_DOWN_MASK_ADC_BIT = 0;
  localparam int TANK_TUNE_REQUEST_BIT = 1;
  localparam int ACTIVE_FILTER_TUNE_REQUEST_BIT = 0;
  localparam int DECIM_K_BIT = 4;
  localparam int DECIM_M_MSB = 3;

  // serial frame: read flag, 7 address bits, 8 data bits
  localparam logic [4:0] SPI_ADDR_DONE = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0F;

  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TUNE_MAX_US = 6000;
  localparam int TUNE_STEP_US = 500;
  localparam int TUNE_STEP_CYCLES = TUNE_STEP_US * (CLK_HZ / 1_000_000);
  localparam int LC_CODE_BITS = 9;
  localparam int RC_CODE_BITS = 8;

  // decimation chain
  localparam logic [7:0] FIRST_COMB_STAGE_RATIO = 8'h0C;
  localparam logic [2:0] FINAL_FIR_STAGE_BY5 = 3'h5;
  localparam logic [2:0] FINAL_FIR_STAGE_BY4 = 3'h4;
  localparam logic [7:0] RATIO_K0 = 8'h3C;
  localparam logic [7:0] RATIO_K1 = 8'h30;
  localparam logic [4:0] NORM5_MUL = 5'h0D;
  localparam int NORM5_SHIFT = 6;
  localparam int NORM4_SHIFT = 2;
  localparam int ACC_W = 44;
  localparam int OUT_LSB = 24;

  // tuning sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LC = 3'b010,
    ST_RC = 3'b100
  } tune_state_e;

  // one baseband output word
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } iq_sample_s;

endpackage

// >>> rtl/comb4_stage.sv
`timescale 1ns/10ps
`default_nettype none
module comb4_stage
  import bpadc_pkg::*;
#(
  parameter int W = 44
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // sync reset, low
  input wire logic [7:0] ratio, // downsampling factor, 0 taken as 1
  input wire logic in_valid, // input sample strobe
  input wire logic [W-1:0] in_data, // input sample
  output logic out_valid, // output strobe
  output logic [W-1:0] out_data // output sample
);
  logic [W-1:0] integ [4];
  logic [W-1:0] dly [4];
  logic [7:0] cnt;
  logic [W-1:0] next_integ [4];
  logic [W-1:0] next_dly [4];
  logic [7:0] next_cnt;
  logic next_out_valid;
  logic [W-1:0] next_out_data;
  logic [W-1:0] stage;
  logic [7:0] last;

  // four integrators, decimation counter, four combs
  always_comb begin
    next_integ = integ;
    next_dly = dly;
    next_cnt = cnt;
    next_out_valid = 1'b0;
    next_out_data = out_data;
    stage = integ[3];
    last = (ratio == 8'h00) ? 8'h00 : ratio - 8'h01;
    if (in_valid) begin
      next_integ[0] = integ[0] + in_data;
      for (int k = 1; k < 4; k++) begin
        next_integ[k] = integ[k] + integ[k-1];
      end
      if (cnt >= last) begin
        next_cnt = 8'h00;
        for (int k = 0; k < 4; k++) begin
          next_dly[k] = stage;
          stage = stage - dly[k];
        end
        next_out_valid = 1'b1;
        next_out_data = stage;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int k = 0; k < 4; k++) begin
        integ[k] <= '0;
        dly[k] <= '0;
      end
      cnt <= 8'h00;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      integ <= next_integ;
      dly <= next_dly;
      cnt <= next_cnt;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/bandpass_adc_tuning_and_decimator.sv
// What this block does
// - both continuous-time resonators are tuned before conversion on leaving standby, when their request bits are set.
// - the discrete-time resonator gets no tuning logic at all.
// - tank capacitor code is set by the tuning engine or by serial writes.
// - tuning codes live in registers and survive standby cycles untouched.
// - tank tuning starts on leaving standby if its request bit is set.
// - tank request bit self-clears when done, within 6 ms.
// - tank code reads back as 3-bit coarse and 6-bit fine registers.
// - filter tuning likewise starts on leaving standby, self-clears, code readable.
// - with both requests set, tank tunes first, then the filter.
// - during tuning no samples and the serial output port stays idle.
// - eighth-rate complex mixer, then three cascaded decimation stages.
// - first stage is a fourth-order comb decimating by 12.
// - second stage is a fourth-order comb decimating by the ratio field.
// - final stage decimates by 5 when select is 0, by 4 when 1.
// - overall ratio is 60 or 48 times the second-stage ratio.
// - pass-band gain variation stays within 1.2 dB and 0.9 dB.
// - band-centre full-scale gain normalised within 0.14 dB for both final-stage lengths; second-stage comb gain varies with the ratio field.
`timescale 1ns/10ps
`default_nettype none
module bandpass_adc_tuning_and_decimator
  import bpadc_pkg::*;
#(
  parameter int STEP_CYCLES = TUNE_STEP_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // sync reset, low
  input wire logic spi_sclk, // serial control clock
  input wire logic spi_cs_n, // serial select, low
  input wire logic spi_mosi, // serial data in
  output logic spi_miso, // serial data out
  output logic spi_miso_oe_n, // data out enable, low drives
  input wire logic signed [3:0] mod_sample, // modulator output word
  input wire logic tune_cmp, // resonance above target flag
  output logic [8:0] lc_cap_drive, // tank capacitor array code
  output logic [7:0] rc_cap_drive, // active filter capacitor code
  output logic tune_busy, // tuning in progress
  output logic converter_active, // converter producing samples
  output logic [7:0] block_standby, // per-block standby mask
  output logic [11:0] overall_ratio, // composite decimation ratio
  output logic sample_valid, // one-cycle output strobe
  output iq_sample_s sample, // baseband output word
  output logic serial_port_enable // serial output port may run
);
  // register bank
  logic [7:0] block_power_down_mask;
  logic [4:0] decim_ctrl;
  logic [1:0] resonator_tune_request;
  logic [2:0] lc_coarse_cap_code;
  logic [5:0] lc_fine_cap_code;
  logic [7:0] rc_cap_code;
  logic [7:0] next_standby;
  logic [4:0] next_decim;
  logic [1:0] next_req;
  logic [8:0] next_lc;
  logic [7:0] next_rc;
  // serial slave
  logic sclk_prev;
  logic [4:0] bit_cnt;
  logic [14:0] in_shift;
  logic [7:0] out_shift;
  logic reading;
  logic [4:0] next_bit_cnt;
  logic [14:0] next_in_shift;
  logic [7:0] next_out_shift;
  logic next_reading;
  logic wr_now;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  tune_state_e state, next_state;
  logic block_power_down_mask_prev;
  logic [3:0] bit_idx, next_bit_idx;
  logic [19:0] timer, next_timer;
  logic leave_standby;
  logic next_active;

  function automatic logic [7:0] read_reg(input logic [6:0] addr);
    case (addr)
      REG_STANDBY: read_reg = block_power_down_mask;
      REG_DECIM: read_reg = {3'h0, decim_ctrl};
      REG_TUNE: read_reg = {6'h00, resonator_tune_request};
      REG_LC_COARSE: read_reg = {5'h00, lc_coarse_cap_code};
      REG_LC_FINE: read_reg = {2'h0, lc_fine_cap_code};
      REG_RC_CODE: read_reg = rc_cap_code;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // serial frame shifter, sampled on sclk edges
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_in_shift = in_shift;
    next_out_shift = out_shift;
    next_reading = reading;
    wr_now = 1'b0;
    wr_addr = in_shift[13:7];
    wr_data = {in_shift[6:0], spi_mosi};
    if (spi_cs_n) begin
      next_bit_cnt = 5'h00;
      next_reading = 1'b0;
    end else if (spi_sclk && !sclk_prev) begin
      next_in_shift = {in_shift[13:0], spi_mosi};
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == SPI_ADDR_DONE) begin
        next_reading = in_shift[6];
        next_out_shift = read_reg({in_shift[5:0], spi_mosi});
      end
      if (bit_cnt == SPI_FRAME_LAST) begin
        wr_now = !in_shift[14];
        next_bit_cnt = 5'h00;
      end
    end else if (!spi_sclk && sclk_prev && bit_cnt > SPI_ADDR_DONE + 5'h01) begin
      next_out_shift = {out_shift[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sclk_prev <= 1'b0;
      bit_cnt <= 5'h00;
      in_shift <= 15'h0000;
      out_shift <= 8'h00;
      reading <= 1'b0;
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      sclk_prev <= spi_sclk;
      bit_cnt <= next_bit_cnt;
      in_shift <= next_in_shift;
      out_shift <= next_out_shift;
      reading <= next_reading;
      spi_miso <= next_out_shift[7];
      spi_miso_oe_n <= !(next_reading && !spi_cs_n);
    end
  end

  // sequencer and register bank next values
  always_comb begin
    next_state = state;
    next_bit_idx = bit_idx;
    next_timer = timer;
    next_standby = block_power_down_mask;
    next_decim = decim_ctrl;
    next_req = resonator_tune_request;
    next_lc = {lc_coarse_cap_code, lc_fine_cap_code};
    next_rc = rc_cap_code;
    leave_standby = block_power_down_mask_prev && !block_power_down_mask[BLOCK_POWER_DOWN_MASK_ADC_BIT];
    case (state)
      ST_IDLE: begin
        if (leave_standby && resonator_tune_request[TANK_TUNE_REQUEST_BIT]) begin
          next_state = ST_LC;
          next_bit_idx = 4'(LC_CODE_BITS - 1);
          next_lc = 9'h100;
          next_timer = 20'h00000;
        end else if (leave_standby && resonator_tune_request[ACTIVE_FILTER_TUNE_REQUEST_BIT]) begin
          next_state = ST_RC;
          next_bit_idx = 4'(RC_CODE_BITS - 1);
          next_rc = 8'h80;
          next_timer = 20'h00000;
        end
      end
      ST_LC: begin
        next_timer = timer + 20'h00001;
        if (timer == 20'(STEP_CYCLES - 1)) begin
          next_timer = 20'h00000;
          // engine sets tank code bit by bit
          if (!tune_cmp) begin
            next_lc[bit_idx] = 1'b0;
          end
          if (bit_idx == 4'h0) begin
            next_req[TANK_TUNE_REQUEST_BIT] = 1'b0;
            if (resonator_tune_request[ACTIVE_FILTER_TUNE_REQUEST_BIT]) begin
              next_state = ST_RC;
              next_bit_idx = 4'(RC_CODE_BITS - 1);
              next_rc = 8'h80;
            end else begin
              next_state = ST_IDLE;
            end
          end else begin
            next_bit_idx = bit_idx - 4'h1;
            next_lc[bit_idx - 4'h1] = 1'b1;
          end
        end
      end
      ST_RC: begin
        next_timer = timer + 20'h00001;
        if (timer == 20'(STEP_CYCLES - 1)) begin
          next_timer = 20'h00000;
          if (!tune_cmp) begin
            next_rc[bit_idx[2:0]] = 1'b0;
          end
          if (bit_idx == 4'h0) begin
            next_req[ACTIVE_FILTER_TUNE_REQUEST_BIT] = 1'b0;
            next_state = ST_IDLE;
          end else begin
            next_bit_idx = bit_idx - 4'h1;
            next_rc[bit_idx[2:0] - 3'h1] = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (wr_now) begin
      case (wr_addr)
        REG_STANDBY: next_standby = wr_data;
        REG_DECIM: next_decim = wr_data[4:0];
        REG_TUNE: next_req = wr_data[1:0];
        REG_LC_COARSE: if (state == ST_IDLE) next_lc[8:6] = wr_data[2:0];
        REG_LC_FINE: if (state == ST_IDLE) next_lc[5:0] = wr_data[5:0];
        REG_RC_CODE: if (state == ST_IDLE) next_rc = wr_data;
        default: next_standby = next_standby;
      endcase
    end
    next_active = !next_standby[BLOCK_POWER_DOWN_MASK_ADC_BIT] && !block_power_down_mask[BLOCK_POWER_DOWN_MASK_ADC_BIT] && next_state == ST_IDLE;
  end

  // codes reset only by reset_n, never by standby
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bit_idx <= 4'h0;
      timer <= 20'h00000;
      block_power_down_mask_prev <= 1'b1;
      block_power_down_mask <= STANDBY_RESET;
      decim_ctrl <= DECIM_RESET;
      resonator_tune_request <= TUNE_RESET;
      lc_coarse_cap_code <= LC_COARSE_RESET;
      lc_fine_cap_code <= LC_FINE_RESET;
      rc_cap_code <= RC_CODE_RESET;
      converter_active <= 1'b0;
      serial_port_enable <= 1'b0;
      tune_busy <= 1'b0;
    end else begin
      state <= next_state;
      bit_idx <= next_bit_idx;
      timer <= next_timer;
      block_power_down_mask_prev <= block_power_down_mask[BLOCK_POWER_DOWN_MASK_ADC_BIT];
      block_power_down_mask <= next_standby;
      decim_ctrl <= next_decim;
      resonator_tune_request <= next_req;
      lc_coarse_cap_code <= next_lc[8:6];
      lc_fine_cap_code <= next_lc[5:0];
      rc_cap_code <= next_rc;
      converter_active <= next_active;
      serial_port_enable <= next_active;
      tune_busy <= next_state != ST_IDLE;
    end
  end

  // code outputs straight from the bank
  assign lc_cap_drive = {lc_coarse_cap_code, lc_fine_cap_code};
  assign rc_cap_drive = rc_cap_code;
  assign block_standby = block_power_down_mask;

  // eighth-rate mixer
  logic [2:0] phase;
  logic signed [7:0] cos_c, sin_c;
  logic signed [11:0] mix_i, mix_q;
  logic [ACC_W-1:0] mi, mq;
  logic mix_valid;

  always_comb begin
    case (phase)
      3'h0: begin cos_c = 8'sh40; sin_c = 8'sh00; end
      3'h1: begin cos_c = 8'sh2D; sin_c = 8'sh2D; end
      3'h2: begin cos_c = 8'sh00; sin_c = 8'sh40; end
      3'h3: begin cos_c = -8'sh2D; sin_c = 8'sh2D; end
      3'h4: begin cos_c = -8'sh40; sin_c = 8'sh00; end
      3'h5: begin cos_c = -8'sh2D; sin_c = -8'sh2D; end
      3'h6: begin cos_c = 8'sh00; sin_c = -8'sh40; end
      default: begin cos_c = 8'sh2D; sin_c = -8'sh2D; end
    endcase
    mix_i = 12'(mod_sample * cos_c);
    mix_q = 12'(-(mod_sample * sin_c));
  end

  // mixer register, one step per sample
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phase <= 3'h0;
      mi <= '0;
      mq <= '0;
      mix_valid <= 1'b0;
    end else begin
      phase <= converter_active ? phase + 3'h1 : 3'h0;
      mi <= ACC_W'(mix_i);
      mq <= ACC_W'(mix_q);
      mix_valid <= converter_active;
    end
  end

  // comb stages for both rails
  logic [7:0] m_ratio;
  logic v1i, v1q, v2i, v2q;
  logic [ACC_W-1:0] d1i, d1q, d2i, d2q;
  assign m_ratio = {4'h0, decim_ctrl[DECIM_M_MSB:0]};

  comb4_stage #(.W(ACC_W)) first_comb_stage_i (.clk_sys(clk_sys), .reset_n(reset_n), .ratio(FIRST_COMB_STAGE_RATIO),
    .in_valid(mix_valid), .in_data(mi), .out_valid(v1i), .out_data(d1i));
  comb4_stage #(.W(ACC_W)) first_comb_stage_q (.clk_sys(clk_sys), .reset_n(reset_n), .ratio(FIRST_COMB_STAGE_RATIO),
    .in_valid(mix_valid), .in_data(mq), .out_valid(v1q), .out_data(d1q));
  comb4_stage #(.W(ACC_W)) second_comb_stage_i (.clk_sys(clk_sys), .reset_n(reset_n), .ratio(m_ratio),
    .in_valid(v1i), .in_data(d1i), .out_valid(v2i), .out_data(d2i));
  comb4_stage #(.W(ACC_W)) second_comb_stage_q (.clk_sys(clk_sys), .reset_n(reset_n), .ratio(m_ratio),
    .in_valid(v1q), .in_data(d1q), .out_valid(v2q), .out_data(d2q));

  // final fir stage
  logic [2:0] f_cnt, next_f_cnt;
  logic [ACC_W-1:0] acc_i, acc_q, next_acc_i, next_acc_q;
  logic next_sample_valid;
  iq_sample_s next_sample;
  logic [ACC_W+4:0] norm_i, norm_q;
  logic [2:0] f_len;
  logic [11:0] next_ratio;

  always_comb begin
    next_f_cnt = f_cnt;
    next_acc_i = acc_i;
    next_acc_q = acc_q;
    next_sample_valid = 1'b0;
    next_sample = sample;
    norm_i = '0;
    norm_q = '0;
    // length 5 or 4 by select bit
    f_len = decim_ctrl[DECIM_K_BIT] ? FINAL_FIR_STAGE_BY4 : FINAL_FIR_STAGE_BY5;
    next_ratio = 12'(m_ratio * (decim_ctrl[DECIM_K_BIT] ? RATIO_K1 : RATIO_K0));
    if (v2i && v2q) begin
      if (f_cnt >= f_len - 3'h1) begin
        next_f_cnt = 3'h0;
        next_acc_i = '0;
        next_acc_q = '0;
        // flat boxcar keeps pass-band droop low
        if (decim_ctrl[DECIM_K_BIT]) begin
          norm_i = (ACC_W+5)'($signed(acc_i + d2i) >>> NORM4_SHIFT);
          norm_q = (ACC_W+5)'($signed(acc_q + d2q) >>> NORM4_SHIFT);
        end else begin
          norm_i = (ACC_W+5)'(($signed(acc_i + d2i) * $signed({1'b0, NORM5_MUL})) >>> NORM5_SHIFT);
          norm_q = (ACC_W+5)'(($signed(acc_q + d2q) * $signed({1'b0, NORM5_MUL})) >>> NORM5_SHIFT);
        end
        next_sample_valid = converter_active;
        next_sample.i = norm_i[OUT_LSB +: 16];
        next_sample.q = norm_q[OUT_LSB +: 16];
      end else begin
        next_f_cnt = f_cnt + 3'h1;
        next_acc_i = acc_i + d2i;
        next_acc_q = acc_q + d2q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      f_cnt <= 3'h0;
      acc_i <= '0;
      acc_q <= '0;
      sample_valid <= 1'b0;
      sample <= '0;
      overall_ratio <= 12'h000;
    end else begin
      f_cnt <= next_f_cnt;
      acc_i <= next_acc_i;
      acc_q <= next_acc_q;
      sample_valid <= next_sample_valid;
      sample <= next_sample;
      overall_ratio <= next_ratio;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/bpadc_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module bpadc_asserts
  import bpadc_pkg::*;
#(
  parameter int STEP_CYCLES = TUNE_STEP_CYCLES
) (
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset, low
  input wire logic spi_cs_n, // select, low
  input wire logic spi_miso_oe_n, // miso enable, low
  input wire logic [8:0] lc_cap_drive, // tank code
  input wire logic [7:0] rc_cap_drive, // filter code
  input wire logic tune_busy, // tuning
  input wire logic converter_active, // running
  input wire logic [7:0] block_standby, // standby mask
  input wire logic [11:0] overall_ratio, // ratio
  input wire logic sample_valid, // word strobe
  input wire logic serial_port_enable // port enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  localparam int BUSY_MAX = 20 * STEP_CYCLES;
  int busy_cnt, next_busy_cnt, gap, next_gap, seen, next_seen;
  logic [11:0] ratio_q;
  // busy length, word spacing and clean-run count
  always_comb begin
    next_busy_cnt = tune_busy ? busy_cnt + 1 : 0;
    next_gap = sample_valid ? 1 : gap + 1;
    next_seen = seen;
    if (!converter_active || overall_ratio != ratio_q) next_seen = 0;
    else if (sample_valid && seen < 3) next_seen = seen + 1;
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busy_cnt <= 0;
      gap <= 0;
      seen <= 0;
      ratio_q <= '0;
    end else begin
      busy_cnt <= next_busy_cnt;
      gap <= next_gap;
      seen <= next_seen;
      ratio_q <= overall_ratio;
    end
  end
  chk_busy_silent: assert property (tune_busy |-> !sample_valid && !serial_port_enable)
    else $error("output activity while tuning");
  chk_active_gate: assert property (converter_active |-> !tune_busy && !block_standby[BLOCK_POWER_DOWN_MASK_ADC_BIT])
    else $error("converter active in standby or tuning");
  chk_tune_on_exit: assert property (
    $rose(tune_busy) |-> !block_standby[BLOCK_POWER_DOWN_MASK_ADC_BIT] && ($past(block_standby[BLOCK_POWER_DOWN_MASK_ADC_BIT], 1)
      || $past(block_standby[BLOCK_POWER_DOWN_MASK_ADC_BIT], 2) || $past(block_standby[BLOCK_POWER_DOWN_MASK_ADC_BIT], 3)))
    else $error("tuning began without a standby exit");
  chk_tune_bounded: assert property (tune_busy |-> busy_cnt < BUSY_MAX)
    else $error("tuning ran too long");
  chk_tank_first: assert property (tune_busy && $changed(rc_cap_drive) |=> $stable(lc_cap_drive)[*4])
    else $error("tank code moved after filter tuning began");
  chk_standby_keeps: assert property (
    !tune_busy && $changed(block_standby) |-> $stable(lc_cap_drive) && $stable(rc_cap_drive))
    else $error("standby change disturbed tuning codes");
  chk_word_spacing: assert property (sample_valid && seen >= 2 |-> gap == overall_ratio)
    else $error("output word spacing differs from ratio");
  chk_miso_release: assert property (spi_cs_n [*5] |-> spi_miso_oe_n)
    else $error("miso driven while deselected");
  cov_tune_end: cover property ($fell(tune_busy));
  cov_rc_step: cover property (tune_busy && $changed(rc_cap_drive));
  cov_spacing: cover property (sample_valid && seen >= 2);
endmodule
`default_nettype wire

// >>> testbench/bpadc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module bpadc_host_model #(
  parameter logic [8:0] TGT_LC = 9'h0B5,
  parameter logic [7:0] TGT_RC = 8'h6D
) (
  input wire logic clk_sys, // clock
  input wire logic spi_miso, // data from device
  input wire logic spi_miso_oe_n, // device drives when low
  input wire logic [8:0] lc_cap_drive, // tank trial code
  input wire logic [7:0] rc_cap_drive, // filter trial code
  output logic spi_sclk, // serial clock, idle low
  output logic spi_cs_n, // select, low
  output logic spi_mosi, // data to device
  output logic tune_cmp // resonance comparator
);
  assign tune_cmp = (lc_cap_drive <= TGT_LC) && (rc_cap_drive <= TGT_RC);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // idle data line keeps toggling so stale bits never look valid
  always @(posedge clk_sys) begin
    if (spi_cs_n) spi_mosi <= ~spi_mosi;
  end
  // one frame, msb first; hp is the half period in clocks, larger for a slow host
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wd, input int hp,
    output logic [7:0] rd_data);
    logic [15:0] frame;
    frame = {rd, addr, wd};
    rd_data = '0;
    @(posedge clk_sys) spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys) spi_sclk <= 1'b0;
      spi_mosi <= frame[i];
      repeat (hp - 1) @(posedge clk_sys);
      @(negedge clk_sys) if (i < 8) rd_data[i] = spi_miso_oe_n ? 1'bx : spi_miso;
      @(posedge clk_sys) spi_sclk <= 1'b1;
      repeat (hp - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys) spi_sclk <= 1'b0;
    @(posedge clk_sys) spi_cs_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> testbench/bandpass_adc_tuning_and_decimator_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bandpass_adc_tuning_and_decimator_tb
  import bpadc_pkg::*;
;
  localparam int STEP = 16;
  localparam logic [8:0] TGT_LC = 9'h0B5;
  localparam logic [7:0] TGT_RC = 8'h6D;
  logic clk_sys, reset_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, tune_cmp;
  logic signed [3:0] mod_sample;
  logic [8:0] lc_cap_drive;
  logic [7:0] rc_cap_drive, block_standby;
  logic tune_busy, converter_active, sample_valid, serial_port_enable;
  logic [11:0] overall_ratio;
  iq_sample_s sample;
  int err_count = 0, checked = 0, cycles = 0, busy_run = 0, busy_len = 0, busy_rises = 0;
  bandpass_adc_tuning_and_decimator #(.STEP_CYCLES(STEP)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .mod_sample(mod_sample),
    .tune_cmp(tune_cmp), .lc_cap_drive(lc_cap_drive), .rc_cap_drive(rc_cap_drive), .tune_busy(tune_busy),
    .converter_active(converter_active), .block_standby(block_standby), .overall_ratio(overall_ratio),
    .sample_valid(sample_valid), .sample(sample), .serial_port_enable(serial_port_enable));
  bpadc_host_model #(.TGT_LC(TGT_LC), .TGT_RC(TGT_RC)) u_host (
    .clk_sys(clk_sys), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .lc_cap_drive(lc_cap_drive),
    .rc_cap_drive(rc_cap_drive), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .tune_cmp(tune_cmp));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // stimulus words, busy bookkeeping, run ceiling
  always @(posedge clk_sys) begin
    mod_sample <= mod_sample + 4'sd3;
    cycles <= cycles + 1;
    if (tune_busy === 1'b1) begin
      busy_run <= busy_run + 1;
      if (busy_run == 0) busy_rises <= busy_rises + 1;
    end else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
    if (cycles == 30000) begin
      err_count = err_count + 1;
      close_out();
    end
  end
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    u_host.xfer(1'b0, addr, data, 2, unused);
  endtask
  task automatic reg_chk(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    u_host.xfer(1'b1, addr, 8'h00, 3, got);
    cmp_val(16'(got), 16'(exp));
  endtask
  // waits for tuning to begin, then checks the converter is silent
  task automatic start_tune();
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (tune_busy !== 1'b1 && n < 8);
    cmp_val(16'(tune_busy), 16'h0001);
    cmp_val(16'({converter_active, serial_port_enable, sample_valid}), 16'h0000);
  endtask
  task automatic poll_clear();
    logic [7:0] v;
    int n;
    n = 0;
    do begin
      u_host.xfer(1'b1, REG_TUNE, 8'h00, 2, v);
      n++;
    end while (v !== 8'h00 && n < 20);
    cmp_val(16'(v), 16'h0000);
  endtask
  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (sample_valid !== 1'b1 && n < 400);
  endtask
  task automatic t_reset();
    reg_chk(REG_STANDBY, 8'hFF);
    reg_chk(REG_TUNE, 8'h00);
    reg_chk(REG_LC_COARSE, 8'h00);
    reg_chk(REG_LC_FINE, 8'h00);
    reg_chk(REG_RC_CODE, 8'h00);
    reg_chk(7'h05, 8'h00);
    cmp_val(16'({block_standby, converter_active}), 16'h01FE);
    cmp_val(16'(overall_ratio), 16'h003C);
    $display("%0t test reset done", $time);
  endtask
  task automatic t_tune_both();
    reg_wr(REG_STANDBY, 8'h45);
    reg_wr(REG_TUNE, 8'h03);
    reg_wr(REG_STANDBY, 8'h44);
    start_tune();
    poll_clear();
    cmp_val(16'(busy_len > 16 * STEP && busy_len <= 18 * STEP), 16'h0001);
    reg_chk(REG_LC_COARSE, 8'(TGT_LC[8:6]));
    reg_chk(REG_LC_FINE, 8'(TGT_LC[5:0]));
    reg_chk(REG_RC_CODE, TGT_RC);
    cmp_val(16'({lc_cap_drive, rc_cap_drive}), 16'({TGT_LC, TGT_RC}));
    cmp_val(16'(converter_active), 16'h0001);
    $display("%0t test tune_both done", $time);
  endtask
  task automatic t_standby_keep();
    int rises;
    rises = busy_rises;
    reg_wr(REG_TUNE, 8'h02);
    reg_chk(REG_TUNE, 8'h02);
    reg_wr(REG_TUNE, 8'h00);
    reg_wr(REG_STANDBY, 8'h45);
    reg_wr(REG_STANDBY, 8'h44);
    repeat (8) @(posedge clk_sys);
    cmp_val(16'(busy_rises - rises), 16'h0000);
    cmp_val(16'({lc_cap_drive, rc_cap_drive}), 16'({TGT_LC, TGT_RC}));
    $display("%0t test standby_keep done", $time);
  endtask
  task automatic t_tank_only();
    reg_wr(REG_STANDBY, 8'h45);
    reg_wr(REG_LC_COARSE, 8'h05);
    reg_wr(REG_LC_FINE, 8'h2A);
    cmp_val(16'(lc_cap_drive), 16'h016A);
    reg_chk(REG_LC_COARSE, 8'h05);
    reg_wr(REG_TUNE, 8'h02);
    reg_wr(REG_STANDBY, 8'h44);
    start_tune();
    poll_clear();
    cmp_val(16'(busy_len > 8 * STEP && busy_len <= 12 * STEP), 16'h0001);
    cmp_val(16'(lc_cap_drive), 16'(TGT_LC));
    cmp_val(16'(rc_cap_drive), 16'(TGT_RC));
    $display("%0t test tank_only done", $time);
  endtask
  task automatic t_decim();
    logic [7:0] cfg [4] = '{8'h01, 8'h11, 8'h03, 8'h12};
    int m, k, gap;
    for (int i = 0; i < 4; i++) begin
      m = cfg[i][3:0];
      k = cfg[i][4];
      reg_wr(REG_DECIM, cfg[i]);
      cmp_val(16'(overall_ratio), 16'(k ? 48 * m : 60 * m));
      repeat (4) wait_pulse(gap);
      cmp_val(16'(gap), 16'(12 * m * (k ? 4 : 5)));
      cmp_val(16'($isunknown(sample)), 16'h0000);
    end
    $display("%0t test decim done", $time);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    mod_sample = 4'sd0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_tune_both();
    t_standby_keep();
    t_tank_only();
    t_decim();
    close_out();
  end
endmodule
bind bandpass_adc_tuning_and_decimator bpadc_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_miso_oe_n(spi_miso_oe_n),
  .lc_cap_drive(lc_cap_drive), .rc_cap_drive(rc_cap_drive), .tune_busy(tune_busy),
  .converter_active(converter_active), .block_standby(block_standby), .overall_ratio(overall_ratio),
  .sample_valid(sample_valid), .serial_port_enable(serial_port_enable));
`default_nettype wire
